// file: design/ludsc_pkg.sv
// Package with register map and constants for the line unit drive and scan port
package ludsc_pkg;
    localparam int          ADDR_W          = 4;
    localparam int          DATA_W          = 8;
    localparam logic [3:0]  DRIVE_OFS       = 4'h0;
    localparam logic [3:0]  SCAN_OFS        = 4'h1;
    localparam logic [3:0]  IRQ_STAT_OFS    = 4'h2;
    localparam logic [3:0]  IRQ_MASK_OFS    = 4'h3;
    localparam int          EQ_BYP_BIT      = 0;
    localparam int          ALL_ONES_BIT    = 1;
    localparam int          CODER_DIS_BIT   = 2;
    localparam int          BUILD_DIS_BIT   = 3;
    localparam int          LOCAL_LOOP_SELECT_BIT       = 4;
    localparam int          REMOTE_LOOP_SELECT_BIT       = 5;
    localparam int          DMO_BIT         = 0;
    localparam int          LOL_BIT         = 1;
    localparam int          LOS_BIT         = 2;
    localparam logic [5:0]  DRIVE_RST       = 6'h00;
    localparam logic [2:0]  SCAN_RST        = 3'h0;
    localparam logic [2:0]  MASK_RST        = 3'h0;
endpackage

// file: design/ludsc_port.sv
// Line unit drive and scan port with register access and change interrupt
//
// Strobed register access and the address map were chosen for this implementation.
`timescale 1ns/1ps
module ludsc_port
    import ludsc_pkg::*;
(
    input  wire logic              clk,
    input  wire logic              resetn,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] wdata,
    input  wire logic              wr_stb,
    input  wire logic              rd_stb,
    output logic      [DATA_W-1:0] rdata,
    output logic                   irq,
    output logic                   equalizer_bypass,
    output logic                   send_all_ones,
    output logic                   line_coder_disable,
    output logic                   build_out_disable,
    output logic                   remote_loop_select,
    output logic                   local_loop_select,
    input  wire logic              drive_monitor_alarm,
    input  wire logic              recovery_lock_lost,
    input  wire logic              signal_loss
);
    // Registered state
    logic [5:0]        drive_ff;
    logic [2:0]        sync1_ff;
    logic [2:0]        scan_ff;
    logic [2:0]        scan_d_ff;
    logic [2:0]        stat_ff;
    logic [2:0]        mask_ff;
    logic [DATA_W-1:0] rdata_ff;
    logic              irq_ff;

    // Next values
    logic [5:0]        nxt_drive;
    logic [2:0]        nxt_mask;
    logic [2:0]        nxt_stat;
    logic [DATA_W-1:0] nxt_rdata;
    logic              nxt_irq;

    // Decode and helper nets
    logic [2:0]        pins_in;
    logic [2:0]        chg_evt;
    logic [2:0]        stat_kept;
    logic              sel_drive;
    logic              sel_scan;
    logic              sel_stat;
    logic              sel_mask;
    logic              wr_drive;
    logic              wr_mask;
    logic              stat_clr;

    // Address match, shared by every register select
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] ofs);
        addr_hit = (a == ofs);
    endfunction

    assign sel_drive = addr_hit(addr, DRIVE_OFS);
    assign sel_scan  = addr_hit(addr, SCAN_OFS);
    assign sel_stat  = addr_hit(addr, IRQ_STAT_OFS);
    assign sel_mask  = addr_hit(addr, IRQ_MASK_OFS);

    // Writes to scan and status fall through and are ignored
    assign wr_drive  = wr_stb && sel_drive;
    assign wr_mask   = wr_stb && sel_mask;
    assign stat_clr  = rd_stb && sel_stat;

    assign pins_in   = {signal_loss, recovery_lock_lost, drive_monitor_alarm};

    // Any edge of a synchronised scan bit is an event
    assign chg_evt   = scan_ff ^ scan_d_ff;

    assign nxt_drive = wr_drive ? wdata[5:0] : drive_ff;
    assign nxt_mask  = wr_mask ? wdata[2:0] : mask_ff;

    // Set wins over the read clear, so no edge is lost
    assign stat_kept = stat_clr ? 3'h0 : stat_ff;
    assign nxt_stat  = stat_kept | chg_evt;

    // New mask takes effect on the same edge as the status
    assign nxt_irq   = |(nxt_stat & nxt_mask);

    // Read data stand for one cycle only, zero otherwise
    assign nxt_rdata = !rd_stb   ? 8'h00 :
                       sel_drive ? {2'h0, drive_ff} :
                       sel_scan  ? {5'h00, scan_ff} :
                       sel_stat  ? {5'h00, stat_ff} :
                       sel_mask  ? {5'h00, mask_ff} : 8'h00;

    // Drive register
    always_ff @(posedge clk)
    begin
        if (!resetn)
            drive_ff <= DRIVE_RST;
        else
            drive_ff <= nxt_drive;
    end

    // Two-stage synchroniser for the line unit alarm pins
    always_ff @(posedge clk)
    begin
        if (!resetn)
        begin
            sync1_ff <= SCAN_RST;
            scan_ff  <= SCAN_RST;
        end
        else
        begin
            sync1_ff <= pins_in;
            scan_ff  <= sync1_ff;
        end
    end

    // Delayed copy of the scan value for edge detection
    always_ff @(posedge clk)
    begin
        if (!resetn)
            scan_d_ff <= SCAN_RST;
        else
            scan_d_ff <= scan_ff;
    end

    // Sticky event status
    always_ff @(posedge clk)
    begin
        if (!resetn)
            stat_ff <= 3'h0;
        else
            stat_ff <= nxt_stat;
    end

    // Interrupt mask
    always_ff @(posedge clk)
    begin
        if (!resetn)
            mask_ff <= MASK_RST;
        else
            mask_ff <= nxt_mask;
    end

    // Read data
    always_ff @(posedge clk)
    begin
        if (!resetn)
            rdata_ff <= 8'h00;
        else
            rdata_ff <= nxt_rdata;
    end

    // Level interrupt
    always_ff @(posedge clk)
    begin
        if (!resetn)
            irq_ff <= 1'b0;
        else
            irq_ff <= nxt_irq;
    end

    assign rdata              = rdata_ff;
    assign irq                = irq_ff;
    assign equalizer_bypass   = drive_ff[EQ_BYP_BIT];
    assign send_all_ones      = drive_ff[ALL_ONES_BIT];
    assign line_coder_disable = drive_ff[CODER_DIS_BIT];
    assign build_out_disable  = drive_ff[BUILD_DIS_BIT];
    assign remote_loop_select = drive_ff[REMOTE_LOOP_SELECT_BIT];
    assign local_loop_select  = drive_ff[LOCAL_LOOP_SELECT_BIT];

    a_drive_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_stb && sel_drive |=> {remote_loop_select, local_loop_select, build_out_disable,
        line_coder_disable, send_all_ones, equalizer_bypass} == $past(wdata[5:0]))
        else $error("drive pins do not follow write");
    a_drive_hold: assert property (@(posedge clk) disable iff (!resetn)
        !(wr_stb && sel_drive) |=> $stable(equalizer_bypass) && $stable(send_all_ones))
        else $error("drive pins changed without write");
    a_loop_pair: assert property (@(posedge clk) disable iff (!resetn)
        !(wr_stb && sel_drive) |=> $stable({remote_loop_select, local_loop_select}))
        else $error("loop pair changed without write");
    a_coder_build: assert property (@(posedge clk) disable iff (!resetn)
        wr_stb && sel_drive |=> line_coder_disable == $past(wdata[2]) && build_out_disable == $past(wdata[3]))
        else $error("coder or build out bit wrong");
    a_scan_read: assert property (@(posedge clk) disable iff (!resetn)
        rd_stb && sel_scan |=> rdata[2:0] == $past(scan_ff) && rdata[7:3] == 5'h00)
        else $error("scan read data wrong");
    a_scan_sync: assert property (@(posedge clk) disable iff (!resetn)
        ##2 scan_ff == $past(pins_in, 2))
        else $error("scan not two stages behind pins");
    a_scan_noside: assert property (@(posedge clk) disable iff (!resetn)
        rd_stb && sel_scan |=> $stable(drive_ff) && $stable(mask_ff))
        else $error("scan read changed state");
    a_idle_rdata: assert property (@(posedge clk) disable iff (!resetn)
        !rd_stb |=> rdata == 8'h00)
        else $error("read data without read");
    a_reset_drive: assert property (@(posedge clk)
        !resetn |=> drive_ff == 6'h00)
        else $error("drive not cleared by reset");
    c_drive_write: cover property (@(posedge clk) disable iff (!resetn) wr_stb && sel_drive);
    c_scan_read: cover property (@(posedge clk) disable iff (!resetn) rd_stb && sel_scan);
    a_mask_write: assert property (@(posedge clk) disable iff (!resetn)
        wr_stb && sel_mask |=> mask_ff == $past(wdata[2:0]))
        else $error("mask does not follow write");
    a_mask_read: assert property (@(posedge clk) disable iff (!resetn)
        rd_stb && sel_mask |=> rdata == {5'h00, $past(mask_ff)})
        else $error("mask read data wrong");
    a_drive_read: assert property (@(posedge clk) disable iff (!resetn)
        rd_stb && sel_drive |=> rdata == {2'h0, $past(drive_ff)})
        else $error("drive read data wrong");
    a_stat_read: assert property (@(posedge clk) disable iff (!resetn)
        rd_stb && sel_stat |=> rdata == {5'h00, $past(stat_ff)})
        else $error("status read data wrong");
    a_stat_set: assert property (@(posedge clk) disable iff (!resetn)
        chg_evt != 3'h0 |=> (stat_ff & $past(chg_evt)) == $past(chg_evt))
        else $error("scan change did not set status");
    a_stat_sticky: assert property (@(posedge clk) disable iff (!resetn)
        !(rd_stb && sel_stat) |=> (stat_ff & $past(stat_ff)) == $past(stat_ff))
        else $error("status bit lost without read");
    a_stat_clear: assert property (@(posedge clk) disable iff (!resetn)
        rd_stb && sel_stat && chg_evt == 3'h0 |=> stat_ff == 3'h0)
        else $error("status not cleared by read");
    a_irq_level: assert property (@(posedge clk) disable iff (!resetn)
        irq == |(stat_ff & mask_ff))
        else $error("interrupt level does not match status and mask");
    a_scan_wr_ign: assert property (@(posedge clk) disable iff (!resetn)
        wr_stb && sel_scan |=> $stable(drive_ff) && $stable(mask_ff))
        else $error("write to scan changed state");
    c_irq_rise: cover property (@(posedge clk) disable iff (!resetn) $rose(irq));
    c_stat_clear: cover property (@(posedge clk) disable iff (!resetn) rd_stb && sel_stat && stat_ff != 3'h0);
    c_loop_digital: cover property (@(posedge clk) disable iff (!resetn) remote_loop_select && local_loop_select);
endmodule

// file: testbench/ludsc_liu_model.sv
// Behavioural model of the line unit: takes the drive pins and reports its alarm levels
`timescale 1ns/1ps
module ludsc_liu_model
(
    input  wire logic [5:0] ctl,
    input  wire logic [2:0] cond,
    output logic      [2:0] alarm
);
    // Cable length choice for build-out stays with software; ctl is left unused
    assign alarm = cond;
endmodule

// file: testbench/ludsc_port_tb.sv
// Self-checking bench for the line unit drive and scan port
`timescale 1ns/1ps
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; $display("mismatch %0t %h %h", $time, a, b); end end
module ludsc_port_tb;
    import ludsc_pkg::*;
    logic              clk = 0, resetn = 0, wr_stb = 0, rd_stb = 0;
    logic [ADDR_W-1:0] addr = '0;
    logic [DATA_W-1:0] wdata = '0, rdata, d;
    logic              irq;
    logic [5:0]        pins;
    logic [2:0]        cond = '0, alarm;
    int                fail_count = 0, checked = 0, cyc = 0;
    logic [15:0]       rows [8] = '{16'hc101, 16'h4202, 16'h8404, 16'h0808, 16'h2020, 16'h3030, 16'h1010, 16'h0000};
    ludsc_port dut (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
        .rdata(rdata), .irq(irq), .equalizer_bypass(pins[0]), .send_all_ones(pins[1]),
        .line_coder_disable(pins[2]), .build_out_disable(pins[3]), .local_loop_select(pins[4]),
        .remote_loop_select(pins[5]), .drive_monitor_alarm(alarm[0]), .recovery_lock_lost(alarm[1]),
        .signal_loss(alarm[2]));
    ludsc_liu_model liu (.ctl(pins), .cond(cond), .alarm(alarm));
    initial forever #5 clk = ~clk;
    always @(posedge clk) if (++cyc == 3000) begin fail_count++; finish_test(); end
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk) begin addr <= a; wdata <= v; wr_stb <= 1'b1; end
        @(posedge clk) wr_stb <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clk) begin addr <= a; rd_stb <= 1'b1; end
        @(posedge clk) rd_stb <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic finish_test();
        if (fail_count == 0 && checked > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    initial
    begin
        repeat (2) @(posedge clk);
        resetn <= 1'b1;
        #1 `CHK(pins, DRIVE_RST)
        foreach (rows[i])
        begin
            wr(DRIVE_OFS, rows[i][15:8]);
            `CHK(pins, rows[i][5:0])
            rd(DRIVE_OFS);
            `CHK(d, {2'h0, rows[i][5:0]})
        end
        rd(4'h7);
        `CHK(d, 8'h00)
        wr(IRQ_MASK_OFS, 8'h07);
        rd(IRQ_MASK_OFS);
        `CHK(d, 8'h07)
        @(posedge clk) cond <= 3'h5;
        repeat (4) @(posedge clk);
        #1 `CHK(irq, 1'b1)
        rd(SCAN_OFS);
        `CHK(d, 8'h05)
        wr(SCAN_OFS, 8'h00);
        rd(SCAN_OFS);
        `CHK(d, 8'h05)
        rd(IRQ_STAT_OFS);
        `CHK(d, 8'h05)
        `CHK(irq, 1'b0)
        wr(IRQ_MASK_OFS, 8'h00);
        @(posedge clk) cond <= 3'h7;
        repeat (4) @(posedge clk);
        #1 `CHK(irq, 1'b0)
        rd(SCAN_OFS);
        `CHK(d, 8'h07)
        rd(IRQ_STAT_OFS);
        `CHK(d, 8'h02)
        wr(DRIVE_OFS, 8'h3f);
        `CHK(pins, 6'h3f)
        @(posedge clk) resetn <= 1'b0;
        @(posedge clk) #1 `CHK(pins, 6'h00)
        finish_test();
    end
endmodule
